// *** fesc_params.svh ***
// Register addresses, field positions, reset values and command codes
`ifndef FESC_PARAMS_SVH
`define FESC_PARAMS_SVH
`define FESC_CMD_WR_EN 8'h06
`define FESC_CMD_RD_ST2 8'h07
`define FESC_CMD_WR_REGS 8'h01
`define FESC_CMD_RD_ANY 8'h65
`define FESC_CMD_WR_ANY 8'h71
`define FESC_CMD_CLR 8'h30
`define FESC_ADDR_ST2 24'h000001
`define FESC_ADDR_CFG1 24'h000002
`define FESC_BIT_EFAIL 6
`define FESC_BIT_PFAIL 5
`define FESC_BIT_ESUS 1
`define FESC_BIT_PHALT 0
`define FESC_BIT_HSD 7
`define FESC_BIT_CMPD 6
`define FESC_LB_LO 2
`define FESC_LB_HI 5
`define FESC_BIT_QUADD 1
`define FESC_BIT_RLOCKD 0
`define FESC_CFG1_RST 8'h00
`define FESC_ST2_RST 8'h00
`define FESC_PMODE_ALL 3'h7
`endif

// *** fesc_pkg.sv ***
// Types shared by the flash error, suspend and config register logic
`include "fesc_params.svh"
package fesc_pkg;
    typedef logic [7:0] fesc_byte_t;
    typedef enum logic [4:0] {
        FESC_CMD  = 5'b00001,
        FESC_ADDR = 5'b00010,
        FESC_DATA = 5'b00100,
        FESC_RD   = 5'b01000,
        FESC_IDLE = 5'b10000
    } fesc_state_e;
endpackage

// *** fesc_regs.sv ***
// Error and suspend status plus non-volatile config one, serial command side
// How it works
// - Status two is returned by the dedicated read and by read-any-register.
// - Status two bits are volatile, hardware set, reset to zero; reserved read zero.
// - Erase fail flag in bit 6 rises when an erase fails.
// - Erase fail also rises on erase of protected sector or locked region.
// - Whole-chip erase hitting any protected sector sets erase fail.
// - Only clear-flags clears the fail flags; register writes leave them.
// - Program fail flag in bit 5 rises when a program fails.
// - Program fail also rises on program into protected sector or locked region.
// - Bit 1 follows erase suspend; writes cannot change it.
// - Bit 0 follows program suspend; writes cannot change it.
// - Config one written by write-registers second byte or write-any-register.
// - Bit 7 is read only zero and seeds the halt status.
// - Bit 6 defaults zero and seeds complement protection.
// - Set region lock bits permanently refuse program and erase to their region.
// - Bit 1 is writable and seeds the four-lane enable after reset.
// - Register-lock default programmable only when protection mode is all ones.
// - Register-lock default locks registers and seeds the volatile register lock.
// - Either fail flag keeps busy set and refuses operations until clear-flags.
`timescale 1ns/1ps
`include "fesc_params.svh"
module fesc_regs
    import fesc_pkg::*;
(
    // Core clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serial link, own clock domain
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // Array engine events, core clock
    input wire logic erase_done,
    input wire logic erase_fault,
    input wire logic erase_prot_hit,
    input wire logic chip_erase_prot_hit,
    input wire logic prog_done,
    input wire logic prog_fault,
    input wire logic prog_prot_hit,
    input wire logic erase_susp,
    input wire logic prog_susp,
    input wire logic engine_busy,
    input wire logic [1:0] op_region,
    input wire logic op_region_valid,
    input wire logic [2:0] protection_mode_field,
    input wire logic register_lock_other,
    // Status and defaults toward the rest of the device
    output logic operation_busy,
    output logic ops_refused,
    output logic region_refuse,
    output logic halt_status_default,
    output logic complement_protection_default,
    output logic four_lane_default,
    output logic register_lock_default,
    output logic [3:0] region_lock_bits
);
    // Link side: command shifter, runs on sck, reset by chip select
    fesc_state_e st_r;
    logic [5:0] cnt_r;
    logic [7:0] cmd_r;
    logic [23:0] addr_r;
    logic [15:0] dat_r;
    logic [7:0] rd_r;
    logic wen_r;
    logic cmd_tgl_r;
    logic [7:0] cmd_code_r;
    logic [23:0] cmd_addr_r;
    logic [15:0] cmd_dat_r;
    logic [7:0] sh_cmd;
    logic [23:0] sh_addr;
    logic [15:0] sh_dat;
    logic cs_tgl_r;
    logic [7:0] st2_sync1_r;
    logic [7:0] st2_sync2_r;
    logic [7:0] cfg_sync1_r;
    logic [7:0] cfg_sync2_r;
    logic [7:0] status_two_volatile;
    logic [7:0] config_one_nonvolatile;
    logic [7:0] rd_sel;

    assign sh_cmd = {cmd_r[6:0], si};
    assign sh_addr = {addr_r[22:0], si};
    assign sh_dat = {dat_r[14:0], si};
    // Read-back chooses status two or config one by address
    assign rd_sel = (addr_r == `FESC_ADDR_ST2) ? st2_sync2_r :
                    (addr_r == `FESC_ADDR_CFG1) ? cfg_sync2_r : 8'h00;

    // Register snapshots for read-out; slowly changing, so multi-bit sync is safe
    // once a read byte starts, the shift copy is frozen anyway
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            st2_sync1_r <= 8'h00;
            st2_sync2_r <= 8'h00;
            cfg_sync1_r <= 8'h00;
            cfg_sync2_r <= 8'h00;
        end else begin
            st2_sync1_r <= status_two_volatile;
            st2_sync2_r <= st2_sync1_r;
            cfg_sync1_r <= config_one_nonvolatile;
            cfg_sync2_r <= cfg_sync1_r;
        end
    end

    // Frame state machine; cs_n high or device reset restarts it since sck may stop
    always_ff @(posedge sck or posedge cs_n or posedge rst) begin
        if (cs_n || rst) begin
            st_r <= FESC_CMD;
            cnt_r <= 6'h00;
            cmd_r <= 8'h00;
            addr_r <= 24'h000000;
            dat_r <= 16'h0000;
            rd_r <= 8'h00;
        end else begin
            case (st_r)
                FESC_CMD: begin
                    cmd_r <= sh_cmd;
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == 6'h07) begin
                        cnt_r <= 6'h00;
                        if (sh_cmd == `FESC_CMD_RD_ST2) begin
                            addr_r <= `FESC_ADDR_ST2;
                            rd_r <= st2_sync2_r;
                            st_r <= FESC_RD;
                        end else if (sh_cmd == `FESC_CMD_RD_ANY || sh_cmd == `FESC_CMD_WR_ANY) begin
                            st_r <= FESC_ADDR;
                        end else if (sh_cmd == `FESC_CMD_WR_REGS) begin
                            st_r <= FESC_DATA;
                        end else begin
                            st_r <= FESC_IDLE;
                        end
                    end
                end
                FESC_ADDR: begin
                    addr_r <= sh_addr;
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == 6'h17) begin
                        cnt_r <= 6'h00;
                        st_r <= (cmd_r == `FESC_CMD_RD_ANY) ? FESC_RD : FESC_DATA;
                    end
                end
                FESC_DATA: begin
                    dat_r <= sh_dat;
                    cnt_r <= (cnt_r == 6'h3F) ? cnt_r : cnt_r + 6'h01;
                end
                FESC_RD: begin
                    rd_r <= {rd_r[6:0], 1'b0};
                    cnt_r <= cnt_r + 6'h01;
                    if (cnt_r == 6'h00 && cmd_r == `FESC_CMD_RD_ANY) begin
                        rd_r <= {rd_sel[6:0], 1'b0};
                    end
                end
                default: st_r <= FESC_IDLE;
            endcase
        end
    end

    // Output bit on the falling edge path is simplified to a flop value
    assign so = (st_r == FESC_RD && cnt_r == 6'h00 && cmd_r == `FESC_CMD_RD_ANY) ?
                rd_sel[7] : rd_r[7];
    assign so_oe = (st_r == FESC_RD) && !cs_n;

    // Frame end: latch decoded command into link-owned holding regs, toggle to core
    always_ff @(posedge cs_n or posedge rst) begin
        if (rst) begin
            cmd_tgl_r <= 1'b0;
            cmd_code_r <= 8'h00;
            cmd_addr_r <= 24'h000000;
            cmd_dat_r <= 16'h0000;
        end else begin
            cmd_tgl_r <= ~cmd_tgl_r;
            cmd_code_r <= cmd_r;
            cmd_addr_r <= addr_r;
            cmd_dat_r <= (cmd_r == `FESC_CMD_WR_REGS) ? dat_r : {dat_r[7:0], dat_r[7:0]};
            // Data count validity carried in code: short writes become no-op
            if (st_r != FESC_CMD && st_r != FESC_RD && st_r != FESC_IDLE &&
                cmd_r == `FESC_CMD_WR_REGS && cnt_r < 6'h10) begin
                cmd_code_r <= 8'h00;
            end
            if (cmd_r == `FESC_CMD_WR_ANY && (st_r != FESC_DATA || cnt_r < 6'h08)) begin
                cmd_code_r <= 8'h00;
            end
        end
    end

    // Core side: toggle crossing; holding regs are stable when pulse seen
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic tgl_s3_r;
    logic cmd_pulse;
    logic [7:0] st2_r;
    logic [7:0] cfg_r;
    logic wr_cfg;
    logic clr_cmd;
    logic [7:0] cfg_new;
    logic reg_locked;
    logic e_set;
    logic p_set;
    logic lock_ok;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
        end else begin
            tgl_s1_r <= cmd_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end
    assign cmd_pulse = tgl_s2_r ^ tgl_s3_r;

    // Decode and gating of register writes
    assign reg_locked = cfg_r[`FESC_BIT_RLOCKD] | register_lock_other;
    assign wr_cfg = cmd_pulse && wen_r && !reg_locked && !operation_busy &&
                    ((cmd_code_r == `FESC_CMD_WR_REGS) ||
                     (cmd_code_r == `FESC_CMD_WR_ANY && cmd_addr_r == `FESC_ADDR_CFG1));
    assign clr_cmd = cmd_pulse && (cmd_code_r == `FESC_CMD_CLR);
    assign lock_ok = (protection_mode_field == `FESC_PMODE_ALL);
    assign e_set = (erase_done && erase_fault) || erase_prot_hit || chip_erase_prot_hit;
    assign p_set = (prog_done && prog_fault) || prog_prot_hit;
    assign region_refuse = op_region_valid && cfg_r[`FESC_LB_LO + op_region];

    // New config value from the low data byte, which is config one for both write forms
    // Bit 7 fixed, lock bits and register-lock only go 0 to 1
    always_comb begin
        cfg_new = cfg_r;
        cfg_new[`FESC_BIT_HSD] = 1'b0;
        cfg_new[`FESC_BIT_CMPD] = cmd_dat_r[`FESC_BIT_CMPD];
        cfg_new[`FESC_LB_HI:`FESC_LB_LO] = cfg_r[`FESC_LB_HI:`FESC_LB_LO] |
                                           cmd_dat_r[`FESC_LB_HI:`FESC_LB_LO];
        cfg_new[`FESC_BIT_QUADD] = cmd_dat_r[`FESC_BIT_QUADD];
        cfg_new[`FESC_BIT_RLOCKD] = cfg_r[`FESC_BIT_RLOCKD] |
                                    (lock_ok & cmd_dat_r[`FESC_BIT_RLOCKD]);
    end

    // Status two: set wins over clear; suspend bits mirror the engine
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st2_r <= `FESC_ST2_RST;
            cfg_r <= `FESC_CFG1_RST;
            wen_r <= 1'b0;
        end else begin
            st2_r[`FESC_BIT_EFAIL] <= e_set | (st2_r[`FESC_BIT_EFAIL] & ~clr_cmd);
            st2_r[`FESC_BIT_PFAIL] <= p_set | (st2_r[`FESC_BIT_PFAIL] & ~clr_cmd);
            st2_r[`FESC_BIT_ESUS] <= erase_susp;
            st2_r[`FESC_BIT_PHALT] <= prog_susp;
            if (wr_cfg) begin
                cfg_r <= cfg_new;
            end
            if (cmd_pulse && cmd_code_r == `FESC_CMD_WR_EN) begin
                wen_r <= 1'b1;
            end else if (wr_cfg || clr_cmd) begin
                wen_r <= 1'b0;
            end
        end
    end

    assign status_two_volatile = {1'b0, st2_r[6:5], 3'h0, st2_r[1:0]};
    assign config_one_nonvolatile = cfg_r;
    assign operation_busy = engine_busy | st2_r[`FESC_BIT_EFAIL] | st2_r[`FESC_BIT_PFAIL];
    assign ops_refused = operation_busy;
    assign halt_status_default = cfg_r[`FESC_BIT_HSD];
    assign complement_protection_default = cfg_r[`FESC_BIT_CMPD];
    assign four_lane_default = cfg_r[`FESC_BIT_QUADD];
    assign register_lock_default = cfg_r[`FESC_BIT_RLOCKD];
    assign region_lock_bits = cfg_r[`FESC_LB_HI:`FESC_LB_LO];

    // Checks; stickiness is checked cycle to cycle so a lost flag shows at once
    a_efail_sets: assert property (@(posedge clock) disable iff (rst)
        e_set |=> st2_r[`FESC_BIT_EFAIL]) else $error("erase fail not set");
    a_pfail_sets: assert property (@(posedge clock) disable iff (rst)
        p_set |=> st2_r[`FESC_BIT_PFAIL]) else $error("program fail not set");
    a_fail_hold: assert property (@(posedge clock) disable iff (rst)
        (st2_r[`FESC_BIT_EFAIL] && !clr_cmd) |=> st2_r[`FESC_BIT_EFAIL])
        else $error("erase fail lost without clear");
    a_pfail_hold: assert property (@(posedge clock) disable iff (rst)
        (st2_r[`FESC_BIT_PFAIL] && !clr_cmd) |=> st2_r[`FESC_BIT_PFAIL])
        else $error("program fail lost without clear");
    a_susp_mirror: assert property (@(posedge clock) disable iff (rst)
        st2_r[`FESC_BIT_ESUS] == $past(erase_susp)) else $error("erase suspend mismatch");
    a_halt_mirror: assert property (@(posedge clock) disable iff (rst)
        st2_r[`FESC_BIT_PHALT] == $past(prog_susp)) else $error("program halt mismatch");
    a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
        status_two_volatile[7] == 1'b0 && status_two_volatile[4:2] == 3'h0)
        else $error("reserved bit set");
    a_busy_fail: assert property (@(posedge clock) disable iff (rst)
        (st2_r[`FESC_BIT_EFAIL] || st2_r[`FESC_BIT_PFAIL]) |-> operation_busy)
        else $error("busy low with fail");
    a_hsd_zero: assert property (@(posedge clock) disable iff (rst)
        !cfg_r[`FESC_BIT_HSD]) else $error("halt default set");
    a_lock_sticky: assert property (@(posedge clock) disable iff (rst)
        $past(cfg_r[`FESC_BIT_RLOCKD]) |-> cfg_r[`FESC_BIT_RLOCKD])
        else $error("register lock cleared");
    a_lb_sticky: assert property (@(posedge clock) disable iff (rst)
        ($past(cfg_r[5:2]) & ~cfg_r[5:2]) == 4'h0) else $error("region lock cleared");
    a_lock_mode: assert property (@(posedge clock) disable iff (rst)
        $rose(cfg_r[`FESC_BIT_RLOCKD]) |-> $past(lock_ok))
        else $error("register lock set outside all-ones mode");
    a_cfg_gated: assert property (@(posedge clock) disable iff (rst)
        (cfg_r != $past(cfg_r)) |->
        ($past(wen_r) && !$past(operation_busy) && !$past(reg_locked)))
        else $error("config changed without enable or while busy or locked");
endmodule

// *** fesc_host.sv ***
// Host serial controller model that frames register commands
`timescale 1ns/1ps
module fesc_host (
    // Serial link toward the device
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // One frame, MSB first; sck stands low outside frames, 30 ns period
    task automatic xfer(input logic [39:0] tx, input int n, input int ncmd,
                        output logic [7:0] rx);
        rx = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = tx[39 - i];
            #15 sck = 1'b1;
            #15 sck = 1'b0;
            // Read data moves after each rising edge, so take it on the fall
            if (i >= ncmd - 1 && i < ncmd + 7)
                rx = {rx[6:0], so};
        end
        #15 cs_n = 1'b1;
        si = ~si; // Deselected line must not keep a stale level
        #30;
    endtask
endmodule

// *** flash_error_suspend_config_regs_tb.sv ***
// Self-checking bench for the error, suspend and config register block
`timescale 1ns/1ps
`include "fesc_params.svh"
module flash_error_suspend_config_regs_tb;
    import fesc_pkg::*;
    typedef struct {string nm; bit core; logic [11:0] v;} fesc_note_s;
    logic clock = 1'b0;
    // Reset rises just after time zero so every edge-triggered reset sees it
    logic rst = 1'b0;
    logic register_lock_other = 1'b0;
    logic [6:0] ev = 7'h00;
    logic erase_susp = 1'b0;
    logic prog_susp = 1'b0;
    logic engine_busy = 1'b0;
    logic op_region_valid = 1'b0;
    logic [1:0] op_region = 2'h0;
    logic [2:0] protection_mode_field = 3'h0;
    logic sck, cs_n, si, so, so_oe;
    logic operation_busy, ops_refused, region_refuse, halt_status_default;
    logic complement_protection_default, four_lane_default, register_lock_default;
    logic [3:0] region_lock_bits;
    fesc_note_s notes[$];
    fesc_note_s n;
    logic [7:0] rx, e;
    logic [11:0] got;
    logic [31:0] seed = 32'h0001053C;
    int fail_count = 0;
    int compares = 0;
    logic [6:0] masks [7] = '{7'h01, 7'h03, 7'h05, 7'h09, 7'h10, 7'h30, 7'h50};
    logic [7:0] flags [7] = '{8'h00, 8'h40, 8'h40, 8'h40, 8'h00, 8'h20, 8'h20};
    event shown;

    always #5 clock = ~clock;

    fesc_regs uut (.clock, .rst, .sck, .cs_n, .si, .so, .so_oe,
        .erase_done(ev[0]), .erase_fault(ev[1]), .erase_prot_hit(ev[2]),
        .chip_erase_prot_hit(ev[3]), .prog_done(ev[4]), .prog_fault(ev[5]),
        .prog_prot_hit(ev[6]), .erase_susp, .prog_susp, .engine_busy, .op_region,
        .op_region_valid, .protection_mode_field, .register_lock_other,
        .operation_busy, .ops_refused, .region_refuse, .halt_status_default,
        .complement_protection_default, .four_lane_default, .register_lock_default,
        .region_lock_bits);
    fesc_host host (.sck, .cs_n, .si, .so);

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic final_report;
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Read status two (address zero means the dedicated command) or config one
    task automatic rd(input logic [23:0] a, input logic [7:0] v, input string nm);
        notes.push_back('{nm, 1'b0, {4'h0, v}});
        if (a == 24'h000000)
            host.xfer({`FESC_CMD_RD_ST2, 32'h0}, 16, 8, rx);
        else
            host.xfer({`FESC_CMD_RD_ANY, a, 8'h00}, 40, 32, rx);
        -> shown;
        #1;
    endtask

    // Core outputs are looked at once the link effect has crossed over
    task automatic chk(input logic [11:0] v, input string nm);
        notes.push_back('{nm, 1'b1, v});
        repeat (8) @(posedge clock);
        #1 -> shown;
        #1;
    endtask

    // Register command, optionally led by the write enable frame
    task automatic wr(input logic [7:0] c, input logic [23:0] a, input logic [7:0] d, input bit en);
        if (en)
            host.xfer({`FESC_CMD_WR_EN, 32'h0}, 8, 99, rx);
        if (c == `FESC_CMD_WR_REGS)
            host.xfer({c, 8'h00, d, 16'h0}, 24, 99, rx);
        else
            host.xfer({c, a, d}, (c == `FESC_CMD_WR_ANY) ? 40 : 8, 99, rx);
        repeat (8) @(posedge clock);
    endtask

    task automatic pulse(input logic [6:0] m);
        @(posedge clock);
        #1 ev = m;
        @(posedge clock);
        #1 ev = 7'h00;
        repeat (8) @(posedge clock);
    endtask

    // Oldest note against what the design shows now
    initial forever begin
        @(shown);
        n = notes.pop_front();
        // Core view: region locks, busy and refuse, defaults, and the idle output enable
        got = n.core ? {region_lock_bits, operation_busy, ops_refused, region_refuse,
            four_lane_default, register_lock_default, complement_protection_default,
            halt_status_default, so_oe} : {4'h0, rx};
        compares++;
        if (got !== n.v) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n.nm, n.v, got);
        end
    end

    // Hang guard, well beyond the roughly eighty microseconds the tests need
    initial begin
        #600000;
        fail_count++;
        $display("[FAIL] watchdog expected end seen hang");
        final_report();
    end

    initial begin
        #1 rst = 1'b1;
        repeat (16) @(posedge clock);
        #1 rst = 1'b0;
        repeat (4) @(posedge clock);
        rd(24'h000000, `FESC_ST2_RST, "st2 dedicated");
        rd(`FESC_ADDR_ST2, `FESC_ST2_RST, "st2 any");
        rd(`FESC_ADDR_CFG1, `FESC_CFG1_RST, "cfg1 reset");
        chk(12'h000, "core idle");
        $display("test reset done");
        // Each event source; register writes must neither clear flags nor land
        for (int k = 0; k < 7; k++) begin
            e = flags[k];
            pulse(masks[k]);
            rd(24'h000000, e, "st2 after event");
            chk((e != 8'h00) ? 12'h0C0 : 12'h000, "busy on fail");
            if (e != 8'h00) begin
                wr(`FESC_CMD_WR_ANY, `FESC_ADDR_ST2, 8'h00, 1'b1);
                wr(`FESC_CMD_WR_REGS, 24'h0, 8'hFF, 1'b1);
                rd(`FESC_ADDR_ST2, e, "st2 after writes");
                rd(`FESC_ADDR_CFG1, 8'h00, "cfg1 while failed");
            end
            wr(`FESC_CMD_CLR, 24'h0, 8'h00, 1'b0);
            rd(24'h000000, 8'h00, "st2 cleared");
        end
        $display("test fail flags done");
        // Random suspend and busy levels; user writes cannot alter the bits
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            @(posedge clock);
            #1 {erase_susp, prog_susp, engine_busy} = seed[2:0];
            wr(`FESC_CMD_WR_ANY, `FESC_ADDR_ST2, ~{6'h00, seed[2:1]}, 1'b1);
            rd(24'h000000, {6'h00, seed[2:1]}, "suspend bits");
            chk({4'h0, seed[0], seed[0], 6'h00}, "busy level");
        end
        @(posedge clock);
        #1 {erase_susp, prog_susp, engine_busy} = 3'h0;
        wr(`FESC_CMD_CLR, 24'h0, 8'h00, 1'b0);
        $display("test suspend done");
        // Config one writes, region locks and the register lock
        wr(`FESC_CMD_WR_ANY, `FESC_ADDR_CFG1, 8'h0A, 1'b1);
        rd(`FESC_ADDR_CFG1, 8'h0A, "cfg1 any write");
        @(posedge clock);
        #1 {op_region_valid, op_region} = 3'h5;
        chk(12'h230, "region locked");
        @(posedge clock);
        #1 op_region = 2'h0;
        chk(12'h210, "region open");
        @(posedge clock);
        #1 op_region_valid = 1'b0;
        wr(`FESC_CMD_WR_ANY, `FESC_ADDR_CFG1, 8'hFF, 1'b0);
        rd(`FESC_ADDR_CFG1, 8'h0A, "no enable");
        // The outside lock source must block an enabled write as well
        @(posedge clock);
        #1 register_lock_other = 1'b1;
        wr(`FESC_CMD_WR_ANY, `FESC_ADDR_CFG1, 8'hFF, 1'b1);
        rd(`FESC_ADDR_CFG1, 8'h0A, "other lock");
        @(posedge clock);
        #1 register_lock_other = 1'b0;
        wr(`FESC_CMD_WR_REGS, 24'h0, 8'hFF, 1'b1);
        rd(`FESC_ADDR_CFG1, 8'h7E, "cfg1 regs write");
        chk(12'hF14, "defaults out");
        wr(`FESC_CMD_WR_REGS, 24'h0, 8'h00, 1'b1);
        rd(`FESC_ADDR_CFG1, 8'h3C, "locks stay");
        @(posedge clock);
        #1 protection_mode_field = `FESC_PMODE_ALL;
        wr(`FESC_CMD_WR_ANY, `FESC_ADDR_CFG1, 8'h41, 1'b1);
        rd(`FESC_ADDR_CFG1, 8'h7D, "reg lock set");
        chk(12'hF0C, "reg lock out");
        wr(`FESC_CMD_WR_ANY, `FESC_ADDR_CFG1, 8'h00, 1'b1);
        rd(`FESC_ADDR_CFG1, 8'h7D, "locked write");
        $display("test config done");
        final_report();
    end
endmodule
